// file: src/isp_consts.svh
// isp_consts.svh: opcodes, field values and wait times of the serial programming port
// Definitions only; included by the port logic
`ifndef ISP_CONSTS_SVH
`define ISP_CONSTS_SVH

`define ISP_CLK_NS       5
`define ISP_T_FLASH_NS   4500000
`define ISP_T_EEP_NS     3600000
`define ISP_T_ERASE_NS   9000000

`define ISP_OP_PREFIX    8'hac
`define ISP_B2_ENABLE    8'h53
`define ISP_B2_ERASE     3'h4
`define ISP_B2_LOCK      3'h7
`define ISP_B2_FUSE      8'ha0
`define ISP_B2_NONE      8'h00
`define ISP_OP_RD_PROG   8'h20
`define ISP_OP_LD_PAGE   8'h40
`define ISP_OP_WR_PAGE   8'h4c
`define ISP_OP_RD_EEP    8'ha0
`define ISP_OP_WR_EEP    8'hc0
`define ISP_OP_LD_EPAGE  8'hc1
`define ISP_OP_WR_EPAGE  8'hc2
`define ISP_OP_RD_LOCK   8'h58
`define ISP_OP_RD_FUSE   8'h50
`define ISP_OP_POLL      8'hf0
`define ISP_H_MASK       8'h08
`define ISP_H_BIT        3
`define ISP_LOCK_PAD     2'h3
`define ISP_ERASED       8'hff
`define ISP_HDR_BITS     5'h17
`define ISP_WORD_BITS    5'h1f
`define ISP_BYTE4_CNT    5'h18

`endif

// file: src/isp_pkg.sv
// isp_pkg: carrier types of the serial programming port
// Assumes isp_consts.svh is on the include path
package isp_pkg;
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] b4;
  } isp_word_s;

  typedef struct packed {
    logic [7:0] op;
    logic [7:0] b2;
    logic [7:0] b3;
  } isp_hdr_s;

  typedef enum logic [1:0] {ST_IDLE, ST_FLASH, ST_EEP, ST_ERASE} isp_busy_e;
endpackage

// file: src/isp_port.sv
// isp_port: serial in-system programming port with flash, EEPROM, lock and fuse storage
// Assumes the programmer masters sck_i and holds tgt_reset_n_i low while programming
//
// Functional notes
// (R1) No program or erase before enable instruction
// (R2) EEPROM write replaces byte, no erase needed
// (R3) Chip erase fills flash and EEPROM with 0xff
// (R4) Programmer keeps sck phases over 2-3 clocks
// (R5) Serial input sampled on sck rising edge
// (R6) Serial output changes on sck falling edge
// (R7) Programmer holds reset, sck low at power-up
// (R8) Programmer waits 20 ms before enabling; the model waits WAIT_EN_CYC (20) clk cycles
// (R9) Enable second byte echoes during third byte
// (R10) Programmer sends four bytes, resyncs via reset
// (R11) Page loads: six address bits, low byte first
// (R12) Write page commits buffer at upper address
// (R13) Programmer waits 4.5 ms after page write
// (R14) Programmer waits 3.6 ms after 0xff rewrite
// (R15) Busy flash page reads back as 0xff
// (R16) Busy EEPROM byte reads back as 0xff
// (R17) Instruction ac 53 enables programming mode
// (R18) Erase instruction clears both arrays, 9 ms
// (R19) Opcode c0 writes EEPROM byte at address
// (R20) Opcode a0 returns EEPROM byte in byte four
// (R21) EEPROM page buffer load then page program
// (R22) Lock bits written by zeros, read back
// (R23) Fuse write stores fourth byte both ways
// (R24) Poll returns busy in last bit
// (R25) Bytes MSB first; act after four bytes
`include "isp_consts.svh"

module isp_port #(
  parameter int FLASH_AW    = 12,
  parameter int PG_AW       = 6,
  parameter int EEP_AW      = 9,
  parameter int EPG_AW      = 2,
  parameter int T_FLASH_CYC = `ISP_T_FLASH_NS / `ISP_CLK_NS,
  parameter int T_EEP_CYC   = `ISP_T_EEP_NS / `ISP_CLK_NS,
  parameter int T_ERASE_CYC = `ISP_T_ERASE_NS / `ISP_CLK_NS
) (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic sck_i,
  input  wire logic mosi_i,
  input  wire logic tgt_reset_n_i,
  output logic      miso_o,
  output logic      prog_en_o,
  output logic      busy_o
);
  import isp_pkg::*;

  localparam int FW  = 2 ** FLASH_AW;
  localparam int PW  = 2 ** PG_AW;
  localparam int EW  = 2 ** EEP_AW;
  localparam int EPW = 2 ** EPG_AW;
  localparam int CW  = 24;

  // Link side, clocked by sck_i
  logic [4:0]  bit_cnt_r;
  logic [31:0] shift_r;
  isp_word_s   word_r;
  isp_hdr_s    hdr_r;
  logic        word_tgl_r;
  logic        hdr_tgl_r;
  logic [7:0]  tx_r;
  logic [7:0]  tx_ld;

  // Core side, clocked by clk_i
  logic        pin_s1_r;
  logic        pin_s2_r;
  logic        wt_s1_r;
  logic        wt_s2_r;
  logic        wt_d_r;
  logic        ht_s1_r;
  logic        ht_s2_r;
  logic        ht_d_r;
  logic        prog_en_r;
  logic        busy_r;
  isp_busy_e   busy_st_r;
  logic [CW-1:0] busy_cnt_r;
  logic [FLASH_AW-PG_AW-1:0] busy_pg_r;
  logic [EEP_AW-1:0] busy_ea_r;
  logic        busy_epg_r;
  logic [7:0]  rd_byte_r;
  logic [15:0] flash_r [FW];
  logic [15:0] pbuf_r [PW];
  logic [7:0]  eep_r [EW];
  logic [7:0]  epbuf_r [EPW];
  logic [5:0]  lock_r;
  logic [7:0]  fuse_r;

  // Link clear: pin high stops programming and realigns the frame
  // (R10) resync by reset
  always_ff @(posedge sck_i or posedge tgt_reset_n_i) begin
    if (tgt_reset_n_i) begin
      bit_cnt_r <= 5'h00;
      shift_r   <= 32'h0000_0000;
    end else begin
      // (R5) rising edge sampling
      bit_cnt_r <= bit_cnt_r + 5'h01;
      // (R25) MSB first shift
      shift_r   <= {shift_r[30:0], mosi_i};
    end
  end

  // Header and word are held for a whole frame, so toggles are enough
  always_ff @(posedge sck_i or posedge tgt_reset_n_i) begin
    if (tgt_reset_n_i) begin
      hdr_r     <= '0;
      hdr_tgl_r <= 1'b0;
    end else if (bit_cnt_r == `ISP_HDR_BITS) begin
      hdr_r     <= {shift_r[22:0], mosi_i};
      hdr_tgl_r <= ~hdr_tgl_r;
    end
  end

  // (R25) act on full word
  always_ff @(posedge sck_i or posedge tgt_reset_n_i) begin
    if (tgt_reset_n_i) begin
      word_r     <= '0;
      word_tgl_r <= 1'b0;
    end else if (bit_cnt_r == `ISP_WORD_BITS) begin
      word_r     <= {shift_r[30:0], mosi_i};
      word_tgl_r <= ~word_tgl_r;
    end
  end

  // Byte four carries the core's answer; other bytes echo the last byte in
  // (R4) answer ready within half sck
  assign tx_ld = (bit_cnt_r == `ISP_BYTE4_CNT) ? rd_byte_r : shift_r[7:0];

  // (R6) falling edge output
  // (R9) byte two echoed in byte three
  always_ff @(negedge sck_i or posedge tgt_reset_n_i) begin
    if (tgt_reset_n_i) begin
      tx_r   <= 8'h00;
      miso_o <= 1'b0;
    end else if (bit_cnt_r[2:0] == 3'h0) begin
      tx_r   <= {tx_ld[6:0], 1'b0};
      miso_o <= tx_ld[7];
    end else begin
      tx_r   <= {tx_r[6:0], 1'b0};
      miso_o <= tx_r[7];
    end
  end

  // Synchronisers: first stage feeds only the second
  always_ff @(posedge clk_i) begin
    pin_s1_r <= tgt_reset_n_i;
    pin_s2_r <= pin_s1_r;
    wt_s1_r  <= word_tgl_r;
    wt_s2_r  <= wt_s1_r;
    wt_d_r   <= wt_s2_r;
    ht_s1_r  <= hdr_tgl_r;
    ht_s2_r  <= ht_s1_r;
    ht_d_r   <= ht_s2_r;
  end

  isp_word_s w;
  isp_hdr_s  h;
  logic word_ev;
  logic hdr_ev;
  logic idle;
  logic go;
  logic pfx;
  logic en_ev;
  logic do_erase;
  logic do_lock;
  logic do_fuse;
  logic do_ldp;
  logic do_wpg;
  logic do_wee;
  logic do_lep;
  logic do_wep;
  logic [FLASH_AW-1:0] wfa;
  logic [FLASH_AW-1:0] rfa;
  logic [EEP_AW-1:0]   wea;
  logic [EEP_AW-1:0]   rea;
  logic [15:0]         fword;
  logic                fl_hit;
  logic                ee_hit;

  assign w       = word_r;
  assign h       = hdr_r;
  assign word_ev = wt_s2_r ^ wt_d_r;
  assign hdr_ev  = ht_s2_r ^ ht_d_r;
  assign idle    = (busy_st_r == ST_IDLE);
  // (R13) writes ignored while busy
  assign go      = word_ev & prog_en_r & idle;
  assign pfx     = (w.op == `ISP_OP_PREFIX);
  // (R17) enable instruction
  assign en_ev   = word_ev & pfx & (w.b2 == `ISP_B2_ENABLE) & ~pin_s2_r;
  // (R18) erase decode
  assign do_erase = go & pfx & (w.b2[7:5] == `ISP_B2_ERASE);
  assign do_lock  = go & pfx & (w.b2[7:5] == `ISP_B2_LOCK);
  assign do_fuse  = go & pfx & (w.b2 == `ISP_B2_FUSE);
  assign do_ldp   = go & ((w.op & ~`ISP_H_MASK) == `ISP_OP_LD_PAGE);
  assign do_wpg   = go & (w.op == `ISP_OP_WR_PAGE);
  assign do_wee   = go & (w.op == `ISP_OP_WR_EEP);
  assign do_lep   = go & (w.op == `ISP_OP_LD_EPAGE);
  assign do_wep   = go & (w.op == `ISP_OP_WR_EPAGE);
  assign wfa      = FLASH_AW'({w.b2[4:0], w.b3});
  assign rfa      = FLASH_AW'({h.b2[4:0], h.b3});
  assign wea      = EEP_AW'({w.b2[1:0], w.b3});
  assign rea      = EEP_AW'({h.b2[1:0], h.b3});
  assign fword    = flash_r[rfa];
  // (R15) busy page hit
  assign fl_hit   = (busy_st_r == ST_FLASH) && (rfa[FLASH_AW-1:PG_AW] == busy_pg_r);
  // (R16) busy byte hit
  assign ee_hit   = (busy_st_r == ST_EEP) &&
                    (busy_epg_r ? (rea[EEP_AW-1:EPG_AW] == busy_ea_r[EEP_AW-1:EPG_AW]) : (rea == busy_ea_r));

  // (R1) enable gate
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || pin_s2_r) begin
      prog_en_r <= 1'b0;
    end else if (en_ev) begin
      prog_en_r <= 1'b1;
    end
  end

  // Self-timed programming; the timer runs on even if the pin goes high
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      busy_st_r  <= ST_IDLE;
      busy_cnt_r <= '0;
    end else begin
      case (busy_st_r)
        ST_IDLE: begin
          if (do_erase) begin
            busy_st_r  <= ST_ERASE;
            busy_cnt_r <= CW'(T_ERASE_CYC - 1);
          end else if (do_wpg) begin
            busy_st_r  <= ST_FLASH;
            busy_cnt_r <= CW'(T_FLASH_CYC - 1);
          end else if (do_wee || do_wep) begin
            busy_st_r  <= ST_EEP;
            busy_cnt_r <= CW'(T_EEP_CYC - 1);
          end
        end
        default: begin
          busy_cnt_r <= busy_cnt_r - CW'(1);
          if (busy_cnt_r == '0) begin
            busy_st_r <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      busy_pg_r  <= '0;
      busy_ea_r  <= '0;
      busy_epg_r <= 1'b0;
    end else if (do_wpg) begin
      busy_pg_r <= wfa[FLASH_AW-1:PG_AW];
    end else if (do_wee || do_wep) begin
      busy_ea_r  <= wea;
      busy_epg_r <= do_wep;
    end
  end

  always_ff @(posedge clk_i) begin
    busy_r <= ~sys_rst_i & (busy_st_r != ST_IDLE);
  end

  // (R11) page buffer load
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < PW; i++) begin
        pbuf_r[i] <= {2{`ISP_ERASED}};
      end
    end else if (do_ldp) begin
      if (w.op[`ISP_H_BIT]) begin
        pbuf_r[w.b3[PG_AW-1:0]][15:8] <= w.b4;
      end else begin
        pbuf_r[w.b3[PG_AW-1:0]][7:0] <= w.b4;
      end
    end
  end

  // Whole page lands in one cycle; the wait only models the cell timing
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || do_erase) begin
      // (R3) flash erased
      for (int i = 0; i < FW; i++) begin
        flash_r[i] <= {2{`ISP_ERASED}};
      end
    end else if (do_wpg) begin
      // (R12) page commit
      for (int i = 0; i < PW; i++) begin
        flash_r[{wfa[FLASH_AW-1:PG_AW], PG_AW'(i)}] <= pbuf_r[i];
      end
    end
  end

  // (R21) EEPROM page buffer
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < EPW; i++) begin
        epbuf_r[i] <= `ISP_ERASED;
      end
    end else if (do_lep) begin
      epbuf_r[w.b3[EPG_AW-1:0]] <= w.b4;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || do_erase) begin
      // (R3) EEPROM erased
      for (int i = 0; i < EW; i++) begin
        eep_r[i] <= `ISP_ERASED;
      end
    end else if (do_wee) begin
      // (R19) byte write
      // (R2) overwrite, no prior erase
      eep_r[wea] <= w.b4;
    end else if (do_wep) begin
      // (R21) page program
      for (int i = 0; i < EPW; i++) begin
        eep_r[{wea[EEP_AW-1:EPG_AW], EPG_AW'(i)}] <= epbuf_r[i];
      end
    end
  end

  // Lock bits only clear by programming; erase restores them
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || do_erase) begin
      lock_r <= 6'h3f;
    end else if (do_lock) begin
      // (R22) zeros program
      lock_r <= lock_r & w.b4[5:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      fuse_r <= `ISP_ERASED;
    end else if (do_fuse) begin
      // (R23) fuse write
      fuse_r <= w.b4;
    end
  end

  // Answer for byte four, built from the first three bytes
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rd_byte_r <= 8'h00;
    end else if (hdr_ev) begin
      rd_byte_r <= h.b3;
      if (prog_en_r) begin
        if ((h.op & ~`ISP_H_MASK) == `ISP_OP_RD_PROG) begin
          // (R15) busy page reads 0xff
          rd_byte_r <= fl_hit ? `ISP_ERASED : (h.op[`ISP_H_BIT] ? fword[15:8] : fword[7:0]);
        end else if (h.op == `ISP_OP_RD_EEP) begin
          // (R20) EEPROM read
          // (R16) busy byte reads 0xff
          rd_byte_r <= ee_hit ? `ISP_ERASED : eep_r[rea];
        end else if (h.op == `ISP_OP_RD_LOCK && h.b2 == `ISP_B2_NONE) begin
          // (R22) lock readback
          rd_byte_r <= {`ISP_LOCK_PAD, lock_r};
        end else if (h.op == `ISP_OP_RD_FUSE && h.b2 == `ISP_B2_NONE) begin
          rd_byte_r <= fuse_r;
        end else if (h.op == `ISP_OP_POLL) begin
          // (R24) busy in bit zero
          rd_byte_r <= {7'h00, ~idle};
        end
      end
    end
  end

  assign prog_en_o = prog_en_r;
  assign busy_o    = busy_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_enable;
    en_ev;
  endsequence

  sequence s_prog_on;
    ##1 prog_en_r;
  endsequence

  property p_enable;
    s_enable |-> s_prog_on;
  endproperty
  a_enable: assert property (p_enable) else $error("enable instruction ignored"); // (R17)

  property p_gate;
    !prog_en_r && idle && word_ev |=> idle && lock_r == $past(lock_r) && fuse_r == $past(fuse_r);
  endproperty
  a_gate: assert property (p_gate) else $error("operation started while disabled"); // (R1)

  sequence s_erase_cmd;
    do_erase;
  endsequence

  property p_erase;
    s_erase_cmd |=> flash_r[0] == {2{`ISP_ERASED}} && eep_r[EW-1] == `ISP_ERASED && busy_st_r == ST_ERASE;
  endproperty
  a_erase: assert property (p_erase) else $error("chip erase incomplete"); // (R3)

  property p_eep_wr;
    do_wee |=> eep_r[$past(wea)] == $past(w.b4) && busy_st_r == ST_EEP;
  endproperty
  a_eep_wr: assert property (p_eep_wr) else $error("EEPROM byte not written"); // (R19)

  property p_page;
    do_wpg |=> flash_r[{$past(wfa[FLASH_AW-1:PG_AW]), PG_AW'(0)}] == $past(pbuf_r[0]);
  endproperty
  a_page: assert property (p_page) else $error("page not committed"); // (R12)

  property p_fl_busy;
    hdr_ev && prog_en_r && fl_hit && (h.op & ~`ISP_H_MASK) == `ISP_OP_RD_PROG |=> rd_byte_r == `ISP_ERASED;
  endproperty
  a_fl_busy: assert property (p_fl_busy) else $error("busy flash page not 0xff"); // (R15)

  property p_poll;
    hdr_ev && prog_en_r && h.op == `ISP_OP_POLL |=> rd_byte_r[0] == $past(busy_st_r != ST_IDLE);
  endproperty
  a_poll: assert property (p_poll) else $error("poll bit wrong"); // (R24)

  property p_lock;
    do_lock |=> lock_r == ($past(lock_r) & $past(w.b4[5:0]));
  endproperty
  a_lock: assert property (p_lock) else $error("lock write wrong"); // (R22)

  property p_fuse;
    do_fuse |=> fuse_r == $past(w.b4);
  endproperty
  a_fuse: assert property (p_fuse) else $error("fuse write wrong"); // (R23)

  property p_ee_rd;
    hdr_ev && prog_en_r && h.op == `ISP_OP_RD_EEP && !ee_hit |=> rd_byte_r == $past(eep_r[rea]);
  endproperty
  a_ee_rd: assert property (p_ee_rd) else $error("EEPROM read wrong"); // (R20)
endmodule

// file: sim/isp_prog_model.sv
// isp_prog_model: behavioural serial programmer, master of the link pins
// Assumes the bench calls its tasks one at a time, never overlapping
module isp_prog_model #(
  parameter int WAIT_EN_CYC = 20
) (
  input  wire logic        clk_i,
  input  wire logic        miso_i,
  output logic             sck_o,
  output logic             mosi_o,
  output logic             tgt_reset_n_o,
  output logic             rx_vld_o,
  output logic [31:0]      rx_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // reset and clock low at power-up
  initial begin
    sck_o = 1'b0;
    mosi_o = 1'b0;
    tgt_reset_n_o = 1'b0;
    rx_vld_o = 1'b0;
    rx_o = 32'h0;
  end

  // positive pin pulse, then settle
  // Settle time scaled far below 20 ms to keep the run short
  task automatic sync();
    @(negedge clk_i);
    tgt_reset_n_o = 1'b1;
    repeat (4) @(negedge clk_i);
    tgt_reset_n_o = 1'b0;
    repeat (WAIT_EN_CYC) @(negedge clk_i);
  endtask

  // long phases, MSB first, four bytes
  task automatic xfer(input logic [31:0] w);
    #1.3;
    for (int i = 31; i >= 0; i--) begin
      mosi_o = w[i];
      #80;
      sck_o = 1'b1;
      rx_o = {rx_o[30:0], miso_i};
      #80;
      sck_o = 1'b0;
    end
    // Released line shows the inverse, not a stale bit
    mosi_o = ~mosi_o;
    rx_vld_o = 1'b1;
    #1;
    rx_vld_o = 1'b0;
  endtask
endmodule

// file: sim/test_isp_port.sv
// test_isp_port: self-checking bench of the serial programming port
// Assumes isp_consts.svh on the include path; programmer model drives the link
module test_isp_port;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int TF = 1500;
  // Long enough that a poll two frames after a write still sees it busy
  localparam int TE = 2500;
  localparam int TC = 2000;

  logic        clk_i;
  logic        sys_rst_i;
  logic        sck;
  logic        mosi;
  logic        rst_n;
  logic        miso;
  logic        prog_en;
  logic        busy;
  logic        rx_vld;
  logic [31:0] rx;
  logic [63:0] exp_q[$];
  logic [63:0] note;
  logic [7:0]  ea;
  logic [7:0]  ed;
  logic [7:0]  d[4];
  int          n_errors = 0;
  int          checks = 0;
  int          cyc = 0;

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  isp_port #(.FLASH_AW(8), .EEP_AW(5), .T_FLASH_CYC(TF), .T_EEP_CYC(TE), .T_ERASE_CYC(TC)) u_dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .sck_i(sck), .mosi_i(mosi), .tgt_reset_n_i(rst_n),
    .miso_o(miso), .prog_en_o(prog_en), .busy_o(busy));

  isp_prog_model u_prog (.clk_i(clk_i), .miso_i(miso), .sck_o(sck), .mosi_o(mosi),
    .tgt_reset_n_o(rst_n), .rx_vld_o(rx_vld), .rx_o(rx));

  task automatic finish_test();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk_rx(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk_flag(input logic g, input logic e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic op(input logic [31:0] w, input logic [31:0] m, input logic [31:0] e);
    exp_q.push_back({m, e});
    u_prog.xfer(w);
  endtask

  task automatic wr(input logic [31:0] w);
    op(w, 32'h0, 32'h0);
  endtask

  task automatic rd(input logic [31:0] w, input logic [7:0] e);
    op(w, 32'hff, {24'h0, e});
  endtask

  task automatic wait_idle();
    repeat (8) @(negedge clk_i);
    for (int k = 0; k < 4000 && busy !== 1'b0; k++)
      @(negedge clk_i);
    chk_flag(busy, 1'b0);
  endtask

  always @(posedge rx_vld) begin
    if (exp_q.size() > 0) begin
      note = exp_q.pop_front();
      if (note[63:32] != 32'h0)
        chk_rx(rx & note[63:32], note[31:0]);
    end
  end

  // Hang guard, well above the expected run length
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 90000) begin
      n_errors++;
      finish_test();
    end
  end

  initial begin
    sys_rst_i = 1'b1;
    void'($urandom(63485));
    repeat (3) @(negedge clk_i);
    sys_rst_i = 1'b0;
    u_prog.sync();
    wr(32'hc000_0343);
    chk_flag(prog_en, 1'b0);
    op(32'hac53_0000, 32'hff00, 32'h5300);
    repeat (8) @(negedge clk_i);
    chk_flag(prog_en, 1'b1);
    rd(32'ha000_0300, 8'hff);
    $display("test enable done");
    ea = 8'($urandom_range(31, 12));
    ed = 8'($urandom_range(254, 0));
    wr({16'hc000, ea, ed});
    chk_flag(busy, 1'b1);
    rd({16'ha000, ea, 8'h0}, 8'hff);
    op(32'hf000_0000, 32'h1, 32'h1);
    wait_idle();
    op(32'hf000_0000, 32'h1, 32'h0);
    rd({16'ha000, ea, 8'h0}, ed);
    wr({16'hc000, ea, ~ed});
    wait_idle();
    rd({16'ha000, ea, 8'h0}, ~ed);
    $display("test eeprom byte done");
    d[0] = 8'($urandom_range(254, 0));
    d[1] = 8'($urandom_range(254, 0));
    wr({24'h40_0005, d[0]});
    wr({24'h48_0005, d[1]});
    wr(32'h4c00_4000);
    rd(32'h2000_4500, 8'hff);
    wait_idle();
    rd(32'h2000_4500, d[0]);
    rd(32'h2800_4500, d[1]);
    $display("test flash page done");
    for (int k = 0; k < 4; k++) begin
      d[k] = 8'($urandom_range(255, 0));
      wr({16'hc100, 8'(k), d[k]});
    end
    wr(32'hc200_0800);
    wait_idle();
    for (int k = 0; k < 4; k++)
      rd({16'ha000, 8'(8 + k), 8'h0}, d[k]);
    $display("test eeprom page done");
    wr(32'hace0_00f5);
    wait_idle();
    rd(32'h5800_0000, 8'hf5);
    foreach (d[k]) begin
      ed = (k[0]) ? 8'h5a : 8'ha5;
      wr({24'haca0_00, ed});
      wait_idle();
      rd(32'h5000_0000, ed);
    end
    $display("test lock fuse done");
    wr(32'hac80_0000);
    op(32'hf000_0000, 32'h1, 32'h1);
    wait_idle();
    rd({16'ha000, ea, 8'h0}, 8'hff);
    rd(32'h2000_4500, 8'hff);
    rd(32'h5800_0000, 8'hff);
    $display("test erase done");
    u_prog.sync();
    chk_flag(prog_en, 1'b0);
    op(32'hac53_0000, 32'hff00, 32'h5300);
    repeat (8) @(negedge clk_i);
    chk_flag(prog_en, 1'b1);
    $display("test resync done");
    #10;
    finish_test();
  end
endmodule
